// ### hw/srr_map.svh
// constants of the soft row repair sequencer
`ifndef SRR_MAP_SVH
`define SRR_MAP_SVH
`define SRR_NUM_BANKS 16
`define SRR_BANK_W 4
`define SRR_ROW_W 18
`define SRR_MR_GUARD 4'h0
`define SRR_MR_MODE 4'h4
`define SRR_MODE_BIT 5
`define SRR_KEY_LOW 7'h7f
`define SRR_KEY1 5'h19
`define SRR_KEY2 5'h0f
`define SRR_KEY3 5'h17
`define SRR_KEY4 5'h07
`define SRR_BURST_LAST 3'h7
`define SRR_HIGH_LAST 3'h3
`define SRR_WL_W 6
`endif

// ### hw/srr_pkg.sv
// types of the soft row repair sequencer
`include "srr_map.svh"
package srr_pkg;
  typedef enum logic [5:0] {
    SRR_OFF = 6'h01,
    SRR_KEYS = 6'h02,
    SRR_ARMED = 6'h04,
    SRR_OPEN = 6'h08,
    SRR_WAITWL = 6'h10,
    SRR_DATA = 6'h20
  } srr_state_type;

  typedef struct packed {
    srr_state_type state;
    logic [1:0] key_idx;
    logic [`SRR_BANK_W-1:0] bank;
    logic [`SRR_ROW_W-1:0] row;
    logic [`SRR_WL_W-1:0] wl_cnt;
    logic [2:0] bit_cnt;
    logic all_low;
    logic first_high;
    logic [`SRR_NUM_BANKS-1:0][`SRR_ROW_W-1:0] rows;
    logic [`SRR_NUM_BANKS-1:0] valid;
    logic mode_on;
    logic repaired;
    logic skipped;
    logic undefined;
    logic ignored;
    logic hit;
    logic [`SRR_ROW_W-1:0] hit_row;
    logic [`SRR_ROW_W-1:0] seed_row;
  } srr_regs_type;
endpackage

// ### hw/srr_sync.sv
// two-flop synchroniser for a bus of independent levels
module srr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ### hw/srr_top.sv
// soft row repair sequencer inside the memory device
`include "srr_map.svh"
module srr_top #(
  parameter int NUM_BANKS = `SRR_NUM_BANKS,
  parameter int DQ_W = 8
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // command pins, sampled on ck
  input wire logic ck,
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [`SRR_ROW_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq,
  // configuration
  input wire logic guard_keys_required,
  input wire logic [`SRR_WL_W-1:0] write_latency,
  input wire logic [NUM_BANKS-1:0] hard_repair_exhausted,
  input wire logic [`SRR_BANK_W-1:0] lookup_bank,
  // status
  output logic mode_enabled,
  output logic [NUM_BANKS-1:0] repair_valid,
  output logic lookup_hit,
  output logic [`SRR_ROW_W-1:0] lookup_row,
  output logic [`SRR_ROW_W-1:0] seed_row,
  output logic last_repaired,
  output logic last_skipped,
  output logic last_undefined,
  output logic last_ignored
);
  localparam int PIN_W = 1 + 5 + 4 + `SRR_ROW_W + DQ_W;

  // elaboration check: the per-bank slots and the bank decode assume this geometry
  if (NUM_BANKS != `SRR_NUM_BANKS || DQ_W < 1)
  begin
    $error("srr_top: unsupported bank count or dq width");
  end

  // ==========================================================
  // reset release and pin synchronisation
  logic [1:0] rst_pipe_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_pipe_reg <= 2'h0;
    else
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end
  assign rst_n = rst_pipe_reg[1];

  logic [PIN_W-1:0] pins_s;
  logic ck_prev_reg;

  // pins all share one sync depth so a command word stays coherent
  srr_sync #(.WIDTH(PIN_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({ck, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr, dq}),
    .q(pins_s)
  );

  logic ck_s, cs_n_s, act_n_s, ras_n_s, cas_n_s, we_n_s;
  logic [3:0] mr_s;
  logic [`SRR_ROW_W-1:0] addr_s;
  logic [DQ_W-1:0] dq_s;
  assign {ck_s, cs_n_s, act_n_s, ras_n_s, cas_n_s, we_n_s, mr_s, addr_s, dq_s} = pins_s;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ck_prev_reg <= 1'b0;
    else if (ce)
      ck_prev_reg <= ck_s;
  end

  // ==========================================================
  // command decode on ck rising edge
  logic ck_rise, ck_fall, cmd, is_act, is_mrs, is_wr, is_pre;
  assign ck_rise = ck_s & ~ck_prev_reg;
  assign ck_fall = ~ck_s & ck_prev_reg;
  assign cmd = ck_rise & ~cs_n_s;
  assign is_act = cmd & ~act_n_s;
  assign is_mrs = cmd & act_n_s & ~ras_n_s & ~cas_n_s & ~we_n_s;
  assign is_wr = cmd & act_n_s & ras_n_s & ~cas_n_s & ~we_n_s;
  assign is_pre = cmd & act_n_s & ~ras_n_s & cas_n_s & ~we_n_s;

  srr_pkg::srr_regs_type state_reg, state_next;
  logic mr4_wr, key_match;
  logic [4:0] key_want;
  assign mr4_wr = is_mrs & (mr_s == `SRR_MR_MODE);

  always_comb
  begin
    unique case (state_reg.key_idx)
      2'h0: key_want = `SRR_KEY1;
      2'h1: key_want = `SRR_KEY2;
      2'h2: key_want = `SRR_KEY3;
      default: key_want = `SRR_KEY4;
    endcase
  end

  assign key_match = is_mrs & (mr_s == `SRR_MR_GUARD) & (addr_s[11:7] == key_want)
    & (addr_s[6:0] == `SRR_KEY_LOW);

  // ==========================================================
  // sequencer
  logic dq_low, dq_high;
  assign dq_low = (dq_s == '0);
  assign dq_high = (dq_s == {DQ_W{1'b1}});

  always_comb
  begin
    state_next = state_reg;
    state_next.hit = state_reg.valid[lookup_bank];
    state_next.hit_row = state_reg.rows[lookup_bank];
    if (mr4_wr)
    begin
      state_next.mode_on = addr_s[`SRR_MODE_BIT];
      state_next.key_idx = 2'h0;
      if (!addr_s[`SRR_MODE_BIT])
        state_next.state = srr_pkg::SRR_OFF;
      else if (guard_keys_required)
        state_next.state = srr_pkg::SRR_KEYS;
      else
        state_next.state = srr_pkg::SRR_ARMED;
    end
    else
    begin
      unique case (state_reg.state)
        srr_pkg::SRR_OFF:
        begin
          state_next.key_idx = 2'h0;
        end
        srr_pkg::SRR_KEYS:
        begin
          if (key_match)
          begin
            state_next.key_idx = state_reg.key_idx + 2'h1;
            if (state_reg.key_idx == 2'h3)
              state_next.state = srr_pkg::SRR_ARMED;
          end
          else if (cmd)
            // any stray command drops entry; later act/wr run as normal accesses
            state_next.state = srr_pkg::SRR_OFF;
        end
        srr_pkg::SRR_ARMED:
        begin
          if (is_act)
          begin
            state_next.bank = {mr_s[3:2], mr_s[1:0]};
            state_next.row = addr_s;
            state_next.seed_row = addr_s;
            state_next.state = srr_pkg::SRR_OPEN;
          end
        end
        srr_pkg::SRR_OPEN:
        begin
          if (is_wr && mr_s == state_reg.bank)
          begin
            state_next.wl_cnt = `SRR_WL_W'(1);
            state_next.state = srr_pkg::SRR_WAITWL;
          end
          else if (is_pre)
            state_next.state = srr_pkg::SRR_ARMED;
        end
        srr_pkg::SRR_WAITWL:
        begin
          if (ck_rise)
          begin
            if (state_reg.wl_cnt >= write_latency)
            begin
              state_next.all_low = dq_low;
              state_next.first_high = dq_high;
              state_next.bit_cnt = 3'h1;
              state_next.state = srr_pkg::SRR_DATA;
            end
            else
              state_next.wl_cnt = state_reg.wl_cnt + `SRR_WL_W'(1);
          end
        end
        srr_pkg::SRR_DATA:
        begin
          if (ck_rise || ck_fall)
          begin
            state_next.all_low = state_reg.all_low & dq_low;
            if (state_reg.bit_cnt <= `SRR_HIGH_LAST)
              state_next.first_high = state_reg.first_high & dq_high;
            state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
            if (state_reg.bit_cnt == `SRR_BURST_LAST)
            begin
              state_next.state = srr_pkg::SRR_OPEN;
              state_next.repaired = 1'b0;
              state_next.skipped = 1'b0;
              state_next.undefined = 1'b0;
              state_next.ignored = 1'b0;
              if (state_reg.all_low && dq_low)
              begin
                if (hard_repair_exhausted[state_reg.bank])
                  state_next.ignored = 1'b1;
                else
                begin
                  // one slot per bank, newest overwrites
                  state_next.rows[state_reg.bank] = state_reg.row;
                  state_next.valid[state_reg.bank] = 1'b1;
                  state_next.repaired = 1'b1;
                end
              end
              else if (state_reg.first_high)
                state_next.skipped = 1'b1;
              else
                // mixed pattern: behaviour is undefined, we choose no repair
                state_next.undefined = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.state <= srr_pkg::SRR_OFF;
    end
    else if (ce)
      state_reg <= state_next;
  end

  assign mode_enabled = state_reg.mode_on;
  assign repair_valid = state_reg.valid;
  assign lookup_hit = state_reg.hit;
  assign lookup_row = state_reg.hit_row;
  assign seed_row = state_reg.seed_row;
  assign last_repaired = state_reg.repaired;
  assign last_skipped = state_reg.skipped;
  assign last_undefined = state_reg.undefined;
  assign last_ignored = state_reg.ignored;
endmodule

// ### sim/srr_properties.sv
// port assertions of the soft row repair sequencer
`include "srr_map.svh"
module srr_properties #(
  parameter int NUM_BANKS = 16
) (
  // clock, reset and enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // configuration and status
  input wire logic [NUM_BANKS-1:0] hard_repair_exhausted,
  input wire logic [`SRR_BANK_W-1:0] lookup_bank,
  input wire logic mode_enabled,
  input wire logic [NUM_BANKS-1:0] repair_valid,
  input wire logic lookup_hit,
  input wire logic [`SRR_ROW_W-1:0] seed_row,
  input wire logic last_repaired,
  input wire logic last_skipped,
  input wire logic last_undefined,
  input wire logic last_ignored
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hit_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hit_q <= 1'b0;
    else if (ce)
      hit_q <= repair_valid[lookup_bank];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_excl; $onehot0({last_repaired, last_skipped, last_undefined, last_ignored}); endproperty
  a_excl: assert property (p_excl) else $error("two outcomes at once");
  property p_keep; (~repair_valid & $past(repair_valid)) == '0; endproperty
  a_keep: assert property (p_keep) else $error("repair lost");
  property p_store; repair_valid != $past(repair_valid) |-> ##[0:1] last_repaired; endproperty
  a_store: assert property (p_store) else $error("store without repair");
  property p_exh; (repair_valid & ~$past(repair_valid) & hard_repair_exhausted) == '0; endproperty
  a_exh: assert property (p_exh) else $error("exhausted bank stored");
  property p_look; lookup_hit == hit_q; endproperty
  a_look: assert property (p_look) else $error("lookup hit wrong");
  property p_skip; $rose(last_skipped) || $rose(last_undefined) |-> $stable(repair_valid); endproperty
  a_skip: assert property (p_skip) else $error("skip stored");
  property p_ign; $rose(last_ignored) |-> $stable(repair_valid) && !last_repaired; endproperty
  a_ign: assert property (p_ign) else $error("ignored stored");
  property p_seed; $changed(seed_row) |-> mode_enabled; endproperty
  a_seed: assert property (p_seed) else $error("seed outside mode");
endmodule
bind srr_top srr_properties #(.NUM_BANKS(NUM_BANKS)) u_props (.clk(clk), .reset_n(reset_n), .ce(ce),
  .hard_repair_exhausted(hard_repair_exhausted), .lookup_bank(lookup_bank), .mode_enabled(mode_enabled),
  .repair_valid(repair_valid), .lookup_hit(lookup_hit), .seed_row(seed_row), .last_repaired(last_repaired),
  .last_skipped(last_skipped), .last_undefined(last_undefined), .last_ignored(last_ignored));

// ### sim/srr_ctl_model.sv
// memory controller model driving command pins and data lines
`include "srr_map.svh"
module srr_ctl_model #(
  parameter int WL = 2
) (
  // clock
  input wire logic clk,
  // pins
  output logic ck = 1'b0,
  output logic cs_n = 1'b1,
  output logic [3:0] cmd_n = 4'hf,
  output logic [3:0] bank = 4'h0,
  output logic [`SRR_ROW_W-1:0] addr = '0,
  output logic [7:0] dq = '1
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // ck of 20 clk; pins move 5 clk away from every ck edge
  always @(posedge clk)
  begin
    cnt <= (cnt == 19) ? 0 : cnt + 1;
    if (cnt == 9)
      ck <= 1'b1;
    if (cnt == 19)
      ck <= 1'b0;
  end
  task automatic cmd(input logic [3:0] c, input logic [3:0] b, input logic [`SRR_ROW_W-1:0] a);
    @(posedge clk iff cnt == 4);
    cs_n <= 1'b0;
    cmd_n <= c;
    bank <= b;
    addr <= a;
    @(posedge clk iff cnt == 14);
    cs_n <= 1'b1;
    addr <= ~a;
  endtask
  task automatic burst(input logic [3:0] b, input logic [7:0] pat);
    int j;
    cmd(4'b1100, b, '0);
    for (j = 2; j <= 2 * WL + 8; j++)
    begin
      @(posedge clk iff (cnt == 4 || cnt == 14));
      dq <= (j >= 2 * WL && j < 2 * WL + 8) ? {8{pat[j - 2 * WL]}} : '1;
    end
  endtask
endmodule

// ### sim/srr_top_tb.sv
// self-checking bench of the soft row repair sequencer
`include "srr_map.svh"
module srr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] f; logic [15:0] v; logic h; logic [17:0] r; logic m; logic [17:0] s;} srr_note_type;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [17:0] sd = '0;
  logic guard = 1'b1;
  logic [3:0] lookup_bank = 4'h0;
  logic [15:0] exh = 16'h0020;
  logic ck, cs_n, mode_enabled, lookup_hit;
  logic [3:0] cmd_n, bank, flags;
  logic [17:0] addr, lookup_row, seed_row;
  logic [7:0] dq;
  logic [15:0] repair_valid;
  logic [15:0] vld = '0;
  logic [17:0] rows [16];
  logic [3:0] cur = '0;
  int errors = 0;
  int checked = 0;
  int seed = 32'h6194de83;
  srr_note_type exp_q [$];
  srr_ctl_model #(.WL(2)) u_ctl (.clk(clk), .ck(ck), .cs_n(cs_n), .cmd_n(cmd_n), .bank(bank), .addr(addr), .dq(dq));
  srr_top u_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .ck(ck), .cs_n(cs_n), .act_n(cmd_n[3]),
    .ras_n(cmd_n[2]), .cas_n(cmd_n[1]), .we_n(cmd_n[0]), .bg(bank[3:2]), .ba(bank[1:0]), .addr(addr), .dq(dq),
    .guard_keys_required(guard), .write_latency(6'h02), .hard_repair_exhausted(exh), .lookup_bank(lookup_bank),
    .mode_enabled(mode_enabled), .repair_valid(repair_valid), .lookup_hit(lookup_hit), .lookup_row(lookup_row),
    .seed_row(seed_row), .last_repaired(flags[3]), .last_skipped(flags[2]), .last_undefined(flags[1]),
    .last_ignored(flags[0]));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] expd);
    checked++;
    if (seen !== expd)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic note(input logic [3:0] b, input logic m);
    lookup_bank <= b;
    exp_q.push_back({cur, vld, vld[b], rows[b], m, sd});
  endtask
  // bad swaps the key pairs so the first key is already wrong
  task automatic repair(input logic bad, input logic [3:0] b, input logic [7:0] pat);
    logic [17:0] r;
    logic [4:0] keys [4];
    int i;
    r = 18'($random(seed));
    keys = '{5'h19, 5'h0f, 5'h17, 5'h07};
    u_ctl.cmd(4'b1000, 4'h4, 18'h00020);
    if (guard)
      for (i = 0; i < 4; i++)
        u_ctl.cmd(4'b1000, 4'h0, {6'h00, keys[bad ? i ^ 1 : i], 7'h7f});
    u_ctl.cmd(4'b0111, b, r);
    u_ctl.burst(b, pat);
    if (!bad)
    begin
      cur = (pat == 8'h00) ? (exh[b] ? 4'h1 : 4'h8) : (pat[3:0] == 4'hf) ? 4'h4 : 4'h2;
      sd = r;
      vld[b] = vld[b] | (cur == 4'h8);
      rows[b] = (cur == 4'h8) ? r : rows[b];
    end
    note(b, 1'b1);
    u_ctl.cmd(4'b1010, b, 18'h00000);
    u_ctl.cmd(4'b1000, 4'h4, 18'h00000);
    note(b, 1'b0);
  endtask
  initial
  begin
    srr_note_type e;
    forever
    begin
      wait (exp_q.size() > 0);
      repeat (8) @(posedge clk);
      #1;
      e = exp_q.pop_front();
      check(flags, e.f);
      check(repair_valid, e.v);
      check(lookup_hit, e.h);
      if (e.h)
        check(lookup_row, e.r);
      check(mode_enabled, e.m);
      check(seed_row, e.s);
    end
  end
  initial
  begin
    repeat (50000) @(posedge clk);
    errors++;
    final_report();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    repair(1'b0, 4'h3, 8'h00);
    repair(1'b0, 4'h3, 8'h00);
    repair(1'b0, 4'ha, 8'h0f);
    repair(1'b0, 4'hc, 8'h01);
    repair(1'b0, 4'h5, 8'h00);
    repair(1'b1, 4'h7, 8'h00);
    guard <= 1'b0;
    repair(1'b0, 4'h9, 8'h00);
    repeat (4) @(posedge clk);
    // bank select moves while the state is frozen; once ce returns the lookup must answer for the new bank
    ce <= 1'b0;
    lookup_bank <= 4'h7;
    repeat (16) @(posedge clk);
    ce <= 1'b1;
    note(4'h7, 1'b0);
    repeat (12) @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    vld = '0;
    cur = '0;
    sd = '0;
    note(4'h3, 1'b0);
    repeat (12) @(posedge clk);
    final_report();
  end
endmodule
